// ===== core/cmps_pkg.sv
// Package of constants and types for the charger mode and protection supervisor.
package cmps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;
    localparam int unsigned OC_LATCH_CYCLES = 8;
    localparam logic [8:0] WDOG_80S = 9'h050;
    localparam logic [8:0] WDOG_160S = 9'h0a0;
    localparam logic [8:0] WDOG_320S = 9'h140;
    localparam logic [1:0] WDOG_OFF = 2'h0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] OC_CNT_RST = 4'h0;
    localparam logic [8:0] WDOG_CNT_RST = 9'h000;

    // ------------------------------------------------------------
    // Modes and current phases
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMPS_IDLE = 2'b00,
        CMPS_CHARGE = 2'b01,
        CMPS_OTG = 2'b10,
        CMPS_FAULT = 2'b11
    } cmps_mode_e;

    typedef enum logic [2:0] {
        CMPS_PH_DEAD = 3'b000,
        CMPS_PH_SHORT = 3'b001,
        CMPS_PH_PRECHG = 3'b010,
        CMPS_PH_FAST = 3'b011,
        CMPS_PH_DONE = 3'b100
    } cmps_phase_e;

    // Battery voltage comparator outputs, each high when above its threshold.
    typedef struct packed {
        logic above_dead;
        logic above_short;
        logic above_low;
        logic above_term;
    } cmps_vbat_s;

    // Host configuration bits.
    typedef struct packed {
        logic fet_current_limit_select;
        logic overcurrent_shutdown_disable;
        logic charge_enable_override;
        logic forced_idle;
        logic otg_request_bit;
        logic [1:0] watchdog_timeout;
        logic [1:0] short_current_select;
        logic [1:0] precharge_current;
    } cmps_cfg_s;

endpackage

// ===== core/cmps_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous input.
`timescale 1ns/10ps
module cmps_sync
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Data
    input wire logic d,
    output logic q
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r <= 1'b0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
            begin
                q_r <= s3_r;
            end
        end
    end

    assign q = q_r;

endmodule

// ===== core/cmps_supervisor.sv
// Charger mode sequencing, protection latches, watchdog and current phase select.
//
// Behaviour
// RQ1: Over-temperature disables the converter and latches the thermal shutdown flag.
// RQ2: In charge or OTG, converter restarts once temperature falls below restart threshold.
// RQ3: Thermal flag stays set after restart until a host read clears it.
// RQ4: Any FET over the selected limit is off for the rest of that cycle.
// RQ5: Eight consecutive limited cycles latch the converter off in charge or OTG.
// RQ6: Overcurrent latch clears by the disable bit or by passing through idle.
// RQ7: With the disable bit set, the eight-cycle latch never happens.
// RQ8: Watchdog expiry without a kick enters fault mode, converter off.
// RQ9: Each kick restarts the watchdog count; the kick bit self-clears.
// RQ10: Two-bit timeout field selects 80 to 320 seconds; 00 disables.
// RQ11: Watchdog off and zeroed in idle, counts after leaving for charge or OTG.
// RQ12: Charge mode is entered only from idle.
// RQ13: Simultaneous OTG and charge requests in idle choose OTG.
// RQ14: Enable pin above threshold is a charge request, below is none.
// RQ15: Override bit forces a charge request; otherwise the pin decides.
// RQ16: Charge entered only with forced-idle clear; forced-idle sends to idle.
// RQ17: In charge mode OTG pin and request bits do not cause exit.
// RQ18: Charge exits to idle on no request, forced-idle, or ship mode.
// RQ19: Charge to OTG always passes through idle.
// RQ20: Below dead select fixed current; dead to short select short-battery fraction.
// RQ21: Short to low select precharge; above low fast charge; above termination zero.
// RQ22: Overcurrent latch drives interrupt low until idle passed and clear written.
// RQ23: Comparator inputs synchronised per clock; watchdog counts a one-second tick.
// RQ24: Watchdog fault mode holds until the device passes through idle.
`timescale 1ns/10ps
module cmps_supervisor
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Analog comparator inputs
    input wire logic over_temp_cmp,
    input wire logic restart_temp_cmp,
    input wire logic [3:0] fet_over_8a5_cmp,
    input wire logic [3:0] fet_over_10a_cmp,
    input wire logic cycle_start,
    input wire cmps_pkg::cmps_vbat_s vbat_cmp,
    // Pins
    input wire logic charge_enable_pin,
    input wire logic otg_request_pin_n,
    input wire logic ship_mode_enter,
    output logic interrupt_out_n,
    // Host configuration and strobes
    input wire cmps_pkg::cmps_cfg_s cfg,
    input wire logic watchdog_kick,
    input wire logic interrupt_clear,
    input wire logic thermal_flag_read,
    // Status and control outputs
    output logic thermal_shutdown_flag,
    output logic overcurrent_latched,
    output logic converter_enable,
    output logic [3:0] fet_gate_enable,
    output logic watchdog_kick_bit,
    output cmps_pkg::cmps_mode_e mode,
    output cmps_pkg::cmps_phase_e charge_phase
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    localparam int NSYNC = 16;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    assign raw_in = {over_temp_cmp, restart_temp_cmp, charge_enable_pin, ~otg_request_pin_n,
                     vbat_cmp, fet_over_8a5_cmp, fet_over_10a_cmp};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            cmps_sync u_sync
            (
                .sys_clk(sys_clk),
                .rst(rst),
                .d(raw_in[gi]),
                .q(syn[gi])
            );
        end
    endgenerate

    logic hot;
    logic cooled;
    logic en_pin;
    logic otg_pin;
    cmps_pkg::cmps_vbat_s vb;
    logic [3:0] over_8a5;
    logic [3:0] over_10a;
    assign hot = syn[15]; // see RQ23
    assign cooled = syn[14];
    assign en_pin = syn[13];
    assign otg_pin = syn[12];
    assign vb = cmps_pkg::cmps_vbat_s'(syn[11:8]);
    assign over_8a5 = syn[7:4];
    assign over_10a = syn[3:0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    cmps_pkg::cmps_mode_e mode_r;
    cmps_pkg::cmps_mode_e mode_nxt;
    logic tsd_active_r;
    logic tsd_flag_r;
    logic oc_latch_r;
    logic oc_irq_r;
    logic oc_idle_seen_r;
    logic [3:0] oc_cnt_r;
    logic [3:0] fet_off_r;
    logic hit_this_cycle_r;
    logic [8:0] wdog_cnt_r;
    logic [24:0] tick_cnt_r;
    logic kick_r;
    cmps_pkg::cmps_phase_e phase_r;

    // ------------------------------------------------------------
    // Requests and mode sequencing
    // ------------------------------------------------------------
    logic chg_req;
    logic otg_req;
    logic wdog_expired;
    logic in_idle;
    assign chg_req = cfg.charge_enable_override | en_pin; // see RQ14 see RQ15
    assign otg_req = otg_pin | cfg.otg_request_bit;
    assign in_idle = (mode_r == cmps_pkg::CMPS_IDLE);

    always_comb
    begin
        mode_nxt = mode_r;
        case (mode_r)
            cmps_pkg::CMPS_IDLE:
            begin
                if (cfg.forced_idle | ship_mode_enter)
                begin
                    mode_nxt = cmps_pkg::CMPS_IDLE; // see RQ16
                end
                else if (otg_req)
                begin
                    mode_nxt = cmps_pkg::CMPS_OTG; // see RQ13
                end
                else if (chg_req)
                begin
                    mode_nxt = cmps_pkg::CMPS_CHARGE; // see RQ12
                end
            end
            cmps_pkg::CMPS_CHARGE:
            begin
                if (cfg.forced_idle | ship_mode_enter | ~chg_req)
                begin
                    mode_nxt = cmps_pkg::CMPS_IDLE; // see RQ17 see RQ18 see RQ19
                end
                else if (wdog_expired)
                begin
                    mode_nxt = cmps_pkg::CMPS_FAULT; // see RQ8
                end
            end
            cmps_pkg::CMPS_OTG:
            begin
                if (cfg.forced_idle | ship_mode_enter | ~otg_req)
                begin
                    mode_nxt = cmps_pkg::CMPS_IDLE;
                end
                else if (wdog_expired)
                begin
                    mode_nxt = cmps_pkg::CMPS_FAULT;
                end
            end
            default:
            begin
                if (cfg.forced_idle | ship_mode_enter)
                begin
                    mode_nxt = cmps_pkg::CMPS_IDLE; // see RQ24
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= cmps_pkg::CMPS_IDLE;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------
    // Thermal shutdown
    // ------------------------------------------------------------
    logic active_mode;
    assign active_mode = (mode_r == cmps_pkg::CMPS_CHARGE) | (mode_r == cmps_pkg::CMPS_OTG);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tsd_active_r <= 1'b0;
            tsd_flag_r <= 1'b0;
        end
        else
        begin
            if (hot)
            begin
                tsd_active_r <= 1'b1; // see RQ1
            end
            else if (cooled & active_mode)
            begin
                tsd_active_r <= 1'b0; // see RQ2
            end
            if (hot)
            begin
                tsd_flag_r <= 1'b1; // see RQ1
            end
            else if (thermal_flag_read & ~tsd_active_r)
            begin
                tsd_flag_r <= 1'b0; // see RQ3
            end
        end
    end

    // ------------------------------------------------------------
    // FET overcurrent
    // ------------------------------------------------------------
    logic [3:0] over_lim;
    logic any_hit;
    assign over_lim = cfg.fet_current_limit_select ? over_10a : over_8a5;
    assign any_hit = |over_lim;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fet_off_r <= 4'h0;
            hit_this_cycle_r <= 1'b0;
            oc_cnt_r <= cmps_pkg::OC_CNT_RST;
            oc_latch_r <= 1'b0;
        end
        else
        begin
            if (cycle_start)
            begin
                fet_off_r <= over_lim; // see RQ4
                hit_this_cycle_r <= any_hit;
                if (~(hit_this_cycle_r | any_hit) | ~active_mode |
                    cfg.overcurrent_shutdown_disable)
                begin
                    oc_cnt_r <= cmps_pkg::OC_CNT_RST;
                end
                else if (oc_cnt_r < 4'(cmps_pkg::OC_LATCH_CYCLES))
                begin
                    oc_cnt_r <= oc_cnt_r + 4'h1; // see RQ5
                end
            end
            else
            begin
                fet_off_r <= fet_off_r | over_lim; // see RQ4
                hit_this_cycle_r <= hit_this_cycle_r | any_hit;
            end
            if (cfg.overcurrent_shutdown_disable | in_idle)
            begin
                oc_latch_r <= 1'b0; // see RQ6 see RQ7
            end
            else if (active_mode & cycle_start &
                     (oc_cnt_r == 4'(cmps_pkg::OC_LATCH_CYCLES - 1)) &
                     (hit_this_cycle_r | any_hit))
            begin
                oc_latch_r <= 1'b1; // see RQ5
            end
        end
    end

    // Interrupt held until idle has been passed and a clear is written.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            oc_irq_r <= 1'b0;
            oc_idle_seen_r <= 1'b0;
        end
        else
        begin
            if (oc_latch_r & ~oc_irq_r)
            begin
                oc_irq_r <= 1'b1; // see RQ22
                oc_idle_seen_r <= 1'b0;
            end
            else if (oc_irq_r)
            begin
                if (in_idle)
                begin
                    oc_idle_seen_r <= 1'b1;
                end
                if (interrupt_clear & oc_idle_seen_r & ~oc_latch_r)
                begin
                    oc_irq_r <= 1'b0; // see RQ22
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    logic tick;
    logic [8:0] wdog_limit;
    assign tick = (tick_cnt_r == 25'(cmps_pkg::TICK_CYCLES - 1)); // see RQ23
    assign wdog_limit = (cfg.watchdog_timeout == 2'h1) ? cmps_pkg::WDOG_80S :
                        (cfg.watchdog_timeout == 2'h2) ? cmps_pkg::WDOG_160S :
                        cmps_pkg::WDOG_320S; // see RQ10
    assign wdog_expired = active_mode & (cfg.watchdog_timeout != cmps_pkg::WDOG_OFF) &
                          (wdog_cnt_r >= wdog_limit); // see RQ8

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_r <= 25'h0;
            wdog_cnt_r <= cmps_pkg::WDOG_CNT_RST;
            kick_r <= 1'b0;
        end
        else
        begin
            kick_r <= watchdog_kick; // see RQ9
            tick_cnt_r <= tick ? 25'h0 : tick_cnt_r + 25'h1;
            if (in_idle | watchdog_kick | (cfg.watchdog_timeout == cmps_pkg::WDOG_OFF))
            begin
                wdog_cnt_r <= cmps_pkg::WDOG_CNT_RST; // see RQ9 see RQ11
            end
            else if (active_mode & tick & (wdog_cnt_r < wdog_limit))
            begin
                wdog_cnt_r <= wdog_cnt_r + 9'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Charge phase
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            phase_r <= cmps_pkg::CMPS_PH_DEAD;
        end
        else if (vb.above_term)
        begin
            phase_r <= cmps_pkg::CMPS_PH_DONE; // see RQ21
        end
        else if (vb.above_low)
        begin
            phase_r <= cmps_pkg::CMPS_PH_FAST; // see RQ21
        end
        else if (vb.above_short)
        begin
            phase_r <= cmps_pkg::CMPS_PH_PRECHG; // see RQ21
        end
        else if (vb.above_dead)
        begin
            phase_r <= cmps_pkg::CMPS_PH_SHORT; // see RQ20
        end
        else
        begin
            phase_r <= cmps_pkg::CMPS_PH_DEAD; // see RQ20
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign converter_enable = active_mode & ~tsd_active_r & ~oc_latch_r; // see RQ1 see RQ5
    assign fet_gate_enable = converter_enable ? ~fet_off_r : 4'h0;
    assign interrupt_out_n = ~oc_irq_r;
    assign thermal_shutdown_flag = tsd_flag_r;
    assign overcurrent_latched = oc_latch_r;
    assign watchdog_kick_bit = kick_r;
    assign mode = mode_r;
    assign charge_phase = phase_r;

endmodule

// ===== verif/cmps_supervisor_props.sv
// Checker of the supervisor's behaviour at its ports.
`timescale 1ns/10ps
module cmps_supervisor_props
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Inputs
    input wire logic over_temp_cmp,
    input wire logic cycle_start,
    input wire logic ship_mode_enter,
    input wire cmps_pkg::cmps_cfg_s cfg,
    input wire logic watchdog_kick,
    input wire logic interrupt_clear,
    // Outputs
    input wire logic interrupt_out_n,
    input wire logic thermal_shutdown_flag,
    input wire logic overcurrent_latched,
    input wire logic converter_enable,
    input wire logic watchdog_kick_bit,
    input wire cmps_pkg::cmps_mode_e mode
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_kick_echo: assert property (watchdog_kick |=> watchdog_kick_bit)
        else $error("kick bit did not follow the kick");
    a_kick_self_clear: assert property
        (watchdog_kick_bit && !watchdog_kick |=> !watchdog_kick_bit)
        else $error("kick bit did not clear itself");
    a_hot_shutdown: assert property
        (over_temp_cmp [*6] |-> thermal_shutdown_flag && !converter_enable)
        else $error("over-temperature left the converter running");
    a_oc_after_cycle: assert property
        ($rose(overcurrent_latched) |->
         $past(cycle_start) && !$past(cfg.overcurrent_shutdown_disable))
        else $error("overcurrent latch outside a cycle start or while disabled");
    a_oc_disable_clears: assert property
        (cfg.overcurrent_shutdown_disable |=> !overcurrent_latched)
        else $error("overcurrent latch set while disabled");
    a_irq_on_latch: assert property ($rose(overcurrent_latched) |=> !interrupt_out_n)
        else $error("interrupt not raised on overcurrent latch");
    a_irq_held: assert property
        (!interrupt_out_n && !interrupt_clear |=> !interrupt_out_n)
        else $error("interrupt released without a clear");
    a_charge_from_idle: assert property
        ($changed(mode) && mode == cmps_pkg::CMPS_CHARGE |-> $past(mode) == cmps_pkg::CMPS_IDLE)
        else $error("charge entered from a mode other than idle");
    a_no_direct_otg: assert property
        ($past(mode) == cmps_pkg::CMPS_CHARGE |-> mode != cmps_pkg::CMPS_OTG)
        else $error("charge went straight to otg");
    a_forced_idle: assert property (cfg.forced_idle |=> mode == cmps_pkg::CMPS_IDLE)
        else $error("forced idle did not hold idle");
    a_otg_wins: assert property
        (mode == cmps_pkg::CMPS_IDLE && cfg.otg_request_bit && cfg.charge_enable_override &&
         !cfg.forced_idle && !ship_mode_enter |=> mode == cmps_pkg::CMPS_OTG)
        else $error("otg did not win over charge");
    c_otg: cover property (mode == cmps_pkg::CMPS_OTG);
    c_oc_latch: cover property ($rose(overcurrent_latched));
    c_thermal_read: cover property ($fell(thermal_shutdown_flag));
endmodule

bind cmps_supervisor cmps_supervisor_props u_props
(
    .sys_clk(sys_clk),
    .rst(rst),
    .over_temp_cmp(over_temp_cmp),
    .cycle_start(cycle_start),
    .ship_mode_enter(ship_mode_enter),
    .cfg(cfg),
    .watchdog_kick(watchdog_kick),
    .interrupt_clear(interrupt_clear),
    .interrupt_out_n(interrupt_out_n),
    .thermal_shutdown_flag(thermal_shutdown_flag),
    .overcurrent_latched(overcurrent_latched),
    .converter_enable(converter_enable),
    .watchdog_kick_bit(watchdog_kick_bit),
    .mode(mode)
);

// ===== verif/cmps_host_model.sv
// Host controller model that services the supervisor with one-cycle strobes.
`timescale 1ns/10ps
module cmps_host_model
#(
    parameter int KICK_GAP = 40
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Commands from the bench
    input wire logic kick_en,
    input wire logic req_clear,
    input wire logic req_read,
    // Strobes to the supervisor
    output logic watchdog_kick,
    output logic interrupt_clear,
    output logic thermal_flag_read
);
    int gap_cnt;
    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            gap_cnt <= 0;
            watchdog_kick <= 1'b0;
            interrupt_clear <= 1'b0;
            thermal_flag_read <= 1'b0;
        end
        else
        begin
            gap_cnt <= (gap_cnt == KICK_GAP - 1) ? 0 : gap_cnt + 1;
            watchdog_kick <= kick_en && (gap_cnt == 0);
            interrupt_clear <= req_clear;
            thermal_flag_read <= req_read;
        end
    end
endmodule

// ===== verif/test_charger_mode_protection_supervisor.sv
// Self-checking testbench of the charger mode and protection supervisor.
`timescale 1ns/10ps
module test_charger_mode_protection_supervisor;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic over_temp_cmp = 1'b0;
    logic restart_temp_cmp = 1'b1;
    logic [3:0] fet_over_8a5_cmp = 4'h0;
    logic [3:0] fet_over_10a_cmp = 4'h0;
    logic cycle_start = 1'b0;
    cmps_pkg::cmps_vbat_s vbat_cmp = 4'h0;
    logic charge_enable_pin = 1'b0;
    logic otg_request_pin_n = 1'b1;
    logic ship_mode_enter = 1'b0;
    cmps_pkg::cmps_cfg_s cfg = 11'h000;
    logic kick_en = 1'b0;
    logic req_clear = 1'b0;
    logic req_read = 1'b0;
    logic watchdog_kick, interrupt_clear, thermal_flag_read, interrupt_out_n;
    logic thermal_shutdown_flag, overcurrent_latched, converter_enable, watchdog_kick_bit;
    logic [3:0] fet_gate_enable;
    cmps_pkg::cmps_mode_e mode;
    cmps_pkg::cmps_phase_e charge_phase;
    int error_cnt = 0;
    int n_checks = 0;
    int i;
    int k;

    cmps_host_model u_host (.sys_clk(sys_clk), .rst(rst), .kick_en(kick_en),
        .req_clear(req_clear), .req_read(req_read), .watchdog_kick(watchdog_kick),
        .interrupt_clear(interrupt_clear), .thermal_flag_read(thermal_flag_read));

    cmps_supervisor DUT (.sys_clk(sys_clk), .rst(rst), .over_temp_cmp(over_temp_cmp),
        .restart_temp_cmp(restart_temp_cmp), .fet_over_8a5_cmp(fet_over_8a5_cmp),
        .fet_over_10a_cmp(fet_over_10a_cmp), .cycle_start(cycle_start), .vbat_cmp(vbat_cmp),
        .charge_enable_pin(charge_enable_pin), .otg_request_pin_n(otg_request_pin_n),
        .ship_mode_enter(ship_mode_enter), .interrupt_out_n(interrupt_out_n), .cfg(cfg),
        .watchdog_kick(watchdog_kick), .interrupt_clear(interrupt_clear),
        .thermal_flag_read(thermal_flag_read), .thermal_shutdown_flag(thermal_shutdown_flag),
        .overcurrent_latched(overcurrent_latched), .converter_enable(converter_enable),
        .fet_gate_enable(fet_gate_enable), .watchdog_kick_bit(watchdog_kick_bit),
        .mode(mode), .charge_phase(charge_phase));

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic look(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wait_mode(input cmps_pkg::cmps_mode_e m);
        int j;
        for (j = 0; j < 20 && mode !== m; j++)
            look(1);
        chk(mode, m);
        if (mode !== m)
            give_verdict();
    endtask
    task automatic pulses(input int n);
        repeat (n)
        begin
            tick(5);
            cycle_start <= 1'b1;
            tick(1);
            cycle_start <= 1'b0;
        end
        look(2);
    endtask
    function automatic cmps_pkg::cmps_phase_e exp_phase(input cmps_pkg::cmps_vbat_s v);
        if (v.above_term)
            return cmps_pkg::CMPS_PH_DONE;
        if (v.above_low)
            return cmps_pkg::CMPS_PH_FAST;
        if (v.above_short)
            return cmps_pkg::CMPS_PH_PRECHG;
        if (v.above_dead)
            return cmps_pkg::CMPS_PH_SHORT;
        return cmps_pkg::CMPS_PH_DEAD;
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h1eb6));
        tick(5);
        rst <= 1'b0;
        look(1);
        chk(mode, cmps_pkg::CMPS_IDLE);
        chk(interrupt_out_n, 1'b1);
        chk(thermal_shutdown_flag, 1'b0);
        tick(1);
        cfg.watchdog_timeout <= 2'($urandom_range(3, 1));
        cfg.short_current_select <= 2'($urandom);
        cfg.precharge_current <= 2'($urandom);
        kick_en <= 1'b1;
        charge_enable_pin <= 1'b1;
        wait_mode(cmps_pkg::CMPS_CHARGE);
        chk(converter_enable, 1'b1);
        tick(1);
        otg_request_pin_n <= 1'b0;
        cfg.otg_request_bit <= 1'b1;
        look(10);
        chk(mode, cmps_pkg::CMPS_CHARGE);
        for (i = 0; i < 60 && watchdog_kick !== 1'b1; i++)
            look(1);
        chk(watchdog_kick, 1'b1);
        if (watchdog_kick !== 1'b1)
            give_verdict();
        look(1);
        chk(watchdog_kick_bit, 1'b1);
        look(1);
        chk(watchdog_kick_bit, 1'b0);
        for (i = 0; i < 10; i++)
        begin
            k = $urandom_range(4);
            tick(1);
            vbat_cmp <= 4'((4'hf << (4 - k)) & 4'hf);
            look(8);
            chk(charge_phase, exp_phase(vbat_cmp));
        end
        tick(1);
        charge_enable_pin <= 1'b0;
        wait_mode(cmps_pkg::CMPS_IDLE);
        wait_mode(cmps_pkg::CMPS_OTG);
        tick(1);
        otg_request_pin_n <= 1'b1;
        cfg.otg_request_bit <= 1'b0;
        wait_mode(cmps_pkg::CMPS_IDLE);
        tick(6);
        cfg.otg_request_bit <= 1'b1;
        cfg.charge_enable_override <= 1'b1;
        look(2);
        chk(mode, cmps_pkg::CMPS_OTG);
        tick(1);
        cfg.otg_request_bit <= 1'b0;
        wait_mode(cmps_pkg::CMPS_IDLE);
        wait_mode(cmps_pkg::CMPS_CHARGE);
        tick(1);
        cfg.forced_idle <= 1'b1;
        look(8);
        chk(mode, cmps_pkg::CMPS_IDLE);
        tick(1);
        cfg.forced_idle <= 1'b0;
        wait_mode(cmps_pkg::CMPS_CHARGE);
        tick(1);
        fet_over_8a5_cmp <= 4'h1;
        look(6);
        chk(fet_gate_enable[0], 1'b0);
        pulses(6);
        tick(1);
        fet_over_8a5_cmp <= 4'h0;
        pulses(2);
        chk(overcurrent_latched, 1'b0);
        tick(1);
        fet_over_8a5_cmp <= 4'h1;
        pulses(8);
        chk(overcurrent_latched, 1'b1);
        chk(converter_enable, 1'b0);
        chk(interrupt_out_n, 1'b0);
        tick(1);
        cfg.overcurrent_shutdown_disable <= 1'b1;
        pulses(9);
        chk(overcurrent_latched, 1'b0);
        chk(interrupt_out_n, 1'b0);
        tick(1);
        cfg.overcurrent_shutdown_disable <= 1'b0;
        cfg.fet_current_limit_select <= 1'b1;
        pulses(9);
        chk(overcurrent_latched, 1'b0);
        tick(1);
        fet_over_8a5_cmp <= 4'h0;
        cfg.forced_idle <= 1'b1;
        tick(3);
        req_clear <= 1'b1;
        tick(1);
        req_clear <= 1'b0;
        look(3);
        chk(interrupt_out_n, 1'b1);
        tick(1);
        cfg.forced_idle <= 1'b0;
        wait_mode(cmps_pkg::CMPS_CHARGE);
        tick(1);
        over_temp_cmp <= 1'b1;
        restart_temp_cmp <= 1'b0;
        look(7);
        chk(thermal_shutdown_flag, 1'b1);
        chk(converter_enable, 1'b0);
        tick(1);
        over_temp_cmp <= 1'b0;
        restart_temp_cmp <= 1'b1;
        look(7);
        chk(converter_enable, 1'b1);
        chk(thermal_shutdown_flag, 1'b1);
        tick(1);
        req_read <= 1'b1;
        tick(1);
        req_read <= 1'b0;
        look(3);
        chk(thermal_shutdown_flag, 1'b0);
        tick(1);
        ship_mode_enter <= 1'b1;
        look(2);
        chk(mode, cmps_pkg::CMPS_IDLE);
        give_verdict();
    end
endmodule
